/* rtl/dlfp_defs.svh */
// constants of the debug-link flash programming register block
// assumes a 200 MHz system clock and byte-wide link registers
`ifndef DLFP_DEFS_SVH
`define DLFP_DEFS_SVH

// ----------------------------------------
// register addresses and reset values
// ----------------------------------------
`define DLFP_ADDR_CTRL 8'h02
`define DLFP_ADDR_DATA 8'hBF
`define DLFP_RST_VAL 8'h00

// ----------------------------------------
// unlock codes and flash commands
// ----------------------------------------
`define DLFP_UNLOCK_1 8'h02
`define DLFP_UNLOCK_2 8'h01
`define DLFP_CMD_BLK_READ 8'h06
`define DLFP_CMD_BLK_WRITE 8'h07
`define DLFP_CMD_PAGE_ERASE 8'h08
`define DLFP_CMD_DEV_ERASE 8'h03

// ----------------------------------------
// link instruction codes and last-bit counts
// ----------------------------------------
`define DLFP_INS_DATA_RD 2'h0
`define DLFP_INS_ADDR_WR 2'h1
`define DLFP_INS_DATA_WR 2'h2
`define DLFP_INS_ADDR_RD 2'h3
`define DLFP_LAST_BIT 3'h7
`define DLFP_INS_LAST 3'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define DLFP_CLK_PERIOD_NS 5
`define DLFP_RST_LOW_NS 20000
`define DLFP_RST_CYC ((`DLFP_RST_LOW_NS + `DLFP_CLK_PERIOD_NS - 1) / `DLFP_CLK_PERIOD_NS)

`endif

/* rtl/dlfp_pkg.sv */
// types of the debug-link flash programming register block
// assumes nothing of its surroundings
package dlfp_pkg;

	typedef enum logic [1:0] {UNLK_IDLE, UNLK_GOT_FIRST, UNLK_OPEN} dlfp_unlock_t;

	typedef enum logic [2:0] {LNK_IDLE, LNK_INS, LNK_WDATA, LNK_WAIT, LNK_RMARK, LNK_RDATA}
		dlfp_link_t;

endpackage : dlfp_pkg

/* rtl/dlfp_sync.sv */
// two-stage synchroniser for levels and toggles
// assumes each bit is a level that may change at any time
`timescale 1ns/1ps

module dlfp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge clk)
	begin
		meta_ff <= din;
		sync_ff <= meta_ff;
	end

	assign dout = sync_ff;

endmodule : dlfp_sync

/* rtl/dlfp_top.sv */
// debug-link flash programming registers: link shifter plus register file
// assumes the programmer clocks the link pin during frames only
// What this block does
// - address 0x02 reaches the 8-bit control register, reset zero, read and write
// - once unlocked, stay out of normal operation until a system reset
// - address 0xBF reaches the 8-bit data register for commands, addresses, data
// - data register accepts commands 0x06, 0x07, 0x08 and 0x03
// - one pin serves as link clock and active-low system reset
// - link address register steers following data reads and writes
`timescale 1ns/1ps
`include "dlfp_defs.svh"

module dlfp_top (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic debug_link_clock_pin,
	input wire logic debug_link_data_pin_in,
	output logic debug_link_data_pin_out,
	output logic debug_link_data_pin_oe_n,
	input wire logic flash_done,
	input wire logic flash_rd_vld,
	input wire logic [7:0] flash_rd_data,
	output logic flash_cmd_vld,
	output logic [7:0] flash_cmd,
	output logic flash_byte_vld,
	output logic [7:0] flash_byte,
	output logic prog_unlocked,
	output logic sys_reset_req
);

	// ----------------------------------------
	// link domain
	// ----------------------------------------
	dlfp_pkg::dlfp_link_t lstate_ff, nxt_lstate;
	logic [2:0] bit_cnt_ff, nxt_bit_cnt;
	logic [1:0] ins_ff, nxt_ins;
	logic [7:0] shift_ff, nxt_shift;
	logic [7:0] wr_hold_ff, nxt_wr_hold;
	logic wr_is_addr_ff, nxt_wr_is_addr;
	logic wr_tgl_ff, nxt_wr_tgl;
	logic rd_is_addr_ff, nxt_rd_is_addr;
	logic rd_tgl_ff, nxt_rd_tgl;
	logic ack_seen_ff, nxt_ack_seen;
	logic dout_ff, nxt_dout;
	logic oe_n_ff, nxt_oe_n;
	logic lnk_rst;
	logic ack_lnk;
	logic ack_tgl_ff;
	logic [7:0] rd_hold_ff;

	dlfp_sync #(.WIDTH(2)) u_sync_lnk (
		.clk(debug_link_clock_pin),
		.din({sys_rst, ack_tgl_ff}),
		.dout({lnk_rst, ack_lnk})
	);

	always_comb
	begin
		nxt_lstate = lstate_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_ins = ins_ff;
		nxt_shift = shift_ff;
		nxt_wr_hold = wr_hold_ff;
		nxt_wr_is_addr = wr_is_addr_ff;
		nxt_wr_tgl = wr_tgl_ff;
		nxt_rd_is_addr = rd_is_addr_ff;
		nxt_rd_tgl = rd_tgl_ff;
		nxt_ack_seen = ack_seen_ff;
		nxt_dout = 1'b0;
		nxt_oe_n = 1'b1;
		unique case (lstate_ff)
			dlfp_pkg::LNK_IDLE:
			begin
				nxt_bit_cnt = 3'h0;
				if (debug_link_data_pin_in)
					nxt_lstate = dlfp_pkg::LNK_INS;
			end
			dlfp_pkg::LNK_INS:
			begin
				nxt_ins = {debug_link_data_pin_in, ins_ff[1]};
				nxt_bit_cnt = bit_cnt_ff + 3'h1;
				if (bit_cnt_ff == `DLFP_INS_LAST)
				begin
					nxt_bit_cnt = 3'h0;
					if (nxt_ins == `DLFP_INS_ADDR_WR || nxt_ins == `DLFP_INS_DATA_WR)
						nxt_lstate = dlfp_pkg::LNK_WDATA;
					else
					begin
						nxt_rd_is_addr = (nxt_ins == `DLFP_INS_ADDR_RD);
						nxt_rd_tgl = ~rd_tgl_ff;
						nxt_oe_n = 1'b0;
						nxt_lstate = dlfp_pkg::LNK_WAIT;
					end
				end
			end
			dlfp_pkg::LNK_WDATA:
			begin
				nxt_shift = {debug_link_data_pin_in, shift_ff[7:1]};
				nxt_bit_cnt = bit_cnt_ff + 3'h1;
				if (bit_cnt_ff == `DLFP_LAST_BIT)
				begin
					nxt_wr_hold = nxt_shift;
					nxt_wr_is_addr = (ins_ff == `DLFP_INS_ADDR_WR);
					nxt_wr_tgl = ~wr_tgl_ff;
					nxt_lstate = dlfp_pkg::LNK_IDLE;
				end
			end
			dlfp_pkg::LNK_WAIT:
			begin
				// drive low until the register side has answered
				nxt_oe_n = 1'b0;
				if (ack_lnk != ack_seen_ff)
				begin
					nxt_ack_seen = ack_lnk;
					nxt_shift = rd_hold_ff;
					nxt_dout = 1'b1;
					nxt_lstate = dlfp_pkg::LNK_RMARK;
				end
			end
			dlfp_pkg::LNK_RMARK, dlfp_pkg::LNK_RDATA:
			begin
				nxt_oe_n = 1'b0;
				nxt_dout = shift_ff[0];
				nxt_shift = {1'b0, shift_ff[7:1]};
				nxt_lstate = dlfp_pkg::LNK_RDATA;
				if (lstate_ff == dlfp_pkg::LNK_RDATA)
					nxt_bit_cnt = bit_cnt_ff + 3'h1;
				if (lstate_ff == dlfp_pkg::LNK_RDATA && bit_cnt_ff == `DLFP_LAST_BIT)
				begin
					nxt_oe_n = 1'b1;
					nxt_dout = 1'b0;
					nxt_lstate = dlfp_pkg::LNK_IDLE;
				end
			end
			default:
				nxt_lstate = dlfp_pkg::LNK_IDLE;
		endcase
	end

	always_ff @(posedge debug_link_clock_pin)
	begin
		if (lnk_rst)
		begin
			lstate_ff <= dlfp_pkg::LNK_IDLE;
			bit_cnt_ff <= 3'h0;
			ins_ff <= 2'h0;
			shift_ff <= 8'h00;
			wr_hold_ff <= 8'h00;
			wr_is_addr_ff <= 1'b0;
			rd_is_addr_ff <= 1'b0;
			dout_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			// toggles start level with the seen copies on the far side
			wr_tgl_ff <= 1'b0;
			rd_tgl_ff <= 1'b0;
			ack_seen_ff <= 1'b0;
		end
		else
		begin
			lstate_ff <= nxt_lstate;
			bit_cnt_ff <= nxt_bit_cnt;
			ins_ff <= nxt_ins;
			shift_ff <= nxt_shift;
			wr_hold_ff <= nxt_wr_hold;
			wr_is_addr_ff <= nxt_wr_is_addr;
			rd_is_addr_ff <= nxt_rd_is_addr;
			dout_ff <= nxt_dout;
			oe_n_ff <= nxt_oe_n;
			wr_tgl_ff <= nxt_wr_tgl;
			rd_tgl_ff <= nxt_rd_tgl;
			ack_seen_ff <= nxt_ack_seen;
		end
	end

	assign debug_link_data_pin_out = dout_ff;
	assign debug_link_data_pin_oe_n = oe_n_ff;

	// ----------------------------------------
	// register domain
	// ----------------------------------------
	logic pin_s, wr_s, rd_s;
	logic wr_seen_ff, rd_seen_ff;
	logic [7:0] addr_ff, nxt_addr;
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic [7:0] data_ff, nxt_data;
	dlfp_pkg::dlfp_unlock_t unlk_ff, nxt_unlk;
	logic unlocked_ff, nxt_unlocked;
	logic cmd_act_ff, nxt_cmd_act;
	logic [7:0] cmd_ff, nxt_cmd;
	logic cmd_vld_ff, nxt_cmd_vld;
	logic byte_vld_ff, nxt_byte_vld;
	logic [7:0] byte_ff, nxt_byte;
	logic [7:0] nxt_rd_hold;
	logic nxt_ack_tgl;
	logic [11:0] rst_cnt_ff, nxt_rst_cnt;
	logic rst_req_ff, nxt_rst_req;
	logic clr, wr_ev, rd_ev, dwr, ctrl_wr, data_wr, legal;

	dlfp_sync #(.WIDTH(3)) u_sync_ref (
		.clk(ref_clk),
		.din({debug_link_clock_pin, wr_tgl_ff, rd_tgl_ff}),
		.dout({pin_s, wr_s, rd_s})
	);

	assign clr = sys_rst || rst_req_ff;
	assign wr_ev = wr_s != wr_seen_ff;
	assign rd_ev = rd_s != rd_seen_ff;
	assign dwr = wr_ev && !wr_is_addr_ff;
	assign ctrl_wr = dwr && addr_ff == `DLFP_ADDR_CTRL;
	assign data_wr = dwr && addr_ff == `DLFP_ADDR_DATA;
	assign legal = wr_hold_ff == `DLFP_CMD_BLK_READ || wr_hold_ff == `DLFP_CMD_BLK_WRITE ||
		wr_hold_ff == `DLFP_CMD_PAGE_ERASE || wr_hold_ff == `DLFP_CMD_DEV_ERASE;

	always_comb
	begin
		nxt_addr = addr_ff;
		nxt_ctrl = ctrl_ff;
		nxt_data = data_ff;
		nxt_unlk = unlk_ff;
		nxt_cmd_act = cmd_act_ff && !flash_done;
		nxt_cmd = cmd_ff;
		nxt_cmd_vld = 1'b0;
		nxt_byte_vld = 1'b0;
		nxt_byte = byte_ff;
		nxt_rd_hold = rd_hold_ff;
		nxt_ack_tgl = ack_tgl_ff;
		// long low on the clock pin is a reset
		nxt_rst_cnt = pin_s ? 12'h000 : rst_cnt_ff + {11'h000, rst_cnt_ff != 12'(`DLFP_RST_CYC)};
		nxt_rst_req = rst_cnt_ff == 12'(`DLFP_RST_CYC);
		if (wr_ev && wr_is_addr_ff)
			nxt_addr = wr_hold_ff;
		if (flash_rd_vld)
			nxt_data = flash_rd_data;
		if (ctrl_wr)
		begin
			nxt_ctrl = wr_hold_ff;
			if (unlk_ff != dlfp_pkg::UNLK_OPEN)
			begin
				if (unlk_ff == dlfp_pkg::UNLK_GOT_FIRST && wr_hold_ff == `DLFP_UNLOCK_2)
					nxt_unlk = dlfp_pkg::UNLK_OPEN;
				else if (wr_hold_ff == `DLFP_UNLOCK_1)
					nxt_unlk = dlfp_pkg::UNLK_GOT_FIRST;
				else
					nxt_unlk = dlfp_pkg::UNLK_IDLE;
			end
		end
		if (data_wr)
		begin
			nxt_data = wr_hold_ff;
			if (unlocked_ff && cmd_act_ff)
			begin
				nxt_byte_vld = 1'b1;
				nxt_byte = wr_hold_ff;
			end
			else if (unlocked_ff && legal)
			begin
				nxt_cmd_act = 1'b1;
				nxt_cmd = wr_hold_ff;
				nxt_cmd_vld = 1'b1;
			end
		end
		nxt_unlocked = nxt_unlk == dlfp_pkg::UNLK_OPEN;
		if (rd_ev)
		begin
			nxt_ack_tgl = ~ack_tgl_ff;
			if (rd_is_addr_ff)
				nxt_rd_hold = addr_ff;
			else if (addr_ff == `DLFP_ADDR_CTRL)
				nxt_rd_hold = ctrl_ff;
			else if (addr_ff == `DLFP_ADDR_DATA)
				nxt_rd_hold = data_ff;
			else
				nxt_rd_hold = `DLFP_RST_VAL;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		// seen copies follow the synced toggles so reset invents no event
		wr_seen_ff <= wr_s;
		rd_seen_ff <= rd_s;
		if (sys_rst)
		begin
			rst_cnt_ff <= 12'h000;
			rst_req_ff <= 1'b0;
			ack_tgl_ff <= 1'b0;
			rd_hold_ff <= `DLFP_RST_VAL;
		end
		else
		begin
			rst_cnt_ff <= nxt_rst_cnt;
			rst_req_ff <= nxt_rst_req;
			ack_tgl_ff <= nxt_ack_tgl;
			rd_hold_ff <= nxt_rd_hold;
		end
		if (clr)
		begin
			addr_ff <= `DLFP_RST_VAL;
			ctrl_ff <= `DLFP_RST_VAL;
			data_ff <= `DLFP_RST_VAL;
			unlk_ff <= dlfp_pkg::UNLK_IDLE;
			unlocked_ff <= 1'b0;
			cmd_act_ff <= 1'b0;
			cmd_ff <= `DLFP_RST_VAL;
			cmd_vld_ff <= 1'b0;
			byte_vld_ff <= 1'b0;
			byte_ff <= `DLFP_RST_VAL;
		end
		else
		begin
			addr_ff <= nxt_addr;
			ctrl_ff <= nxt_ctrl;
			data_ff <= nxt_data;
			unlk_ff <= nxt_unlk;
			unlocked_ff <= nxt_unlocked;
			cmd_act_ff <= nxt_cmd_act;
			cmd_ff <= nxt_cmd;
			cmd_vld_ff <= nxt_cmd_vld;
			byte_vld_ff <= nxt_byte_vld;
			byte_ff <= nxt_byte;
		end
	end

	assign flash_cmd_vld = cmd_vld_ff;
	assign flash_cmd = cmd_ff;
	assign flash_byte_vld = byte_vld_ff;
	assign flash_byte = byte_ff;
	assign prog_unlocked = unlocked_ff;
	assign sys_reset_req = rst_req_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	AST_CTRL_WRITE: assert property (ctrl_wr && !rst_req_ff |=> ctrl_ff == $past(wr_hold_ff))
		else $error("control register missed a write");
	AST_UNLOCK_SEQ: assert property (ctrl_wr && !rst_req_ff && unlk_ff == dlfp_pkg::UNLK_GOT_FIRST
		&& wr_hold_ff == `DLFP_UNLOCK_2 |=> prog_unlocked)
		else $error("unlock sequence did not open programming");
	AST_UNLOCK_HOLD: assert property (prog_unlocked && !rst_req_ff |=> prog_unlocked)
		else $error("programming unlock dropped without reset");
	AST_DATA_WRITE: assert property (data_wr && !flash_rd_vld && !rst_req_ff
		|=> data_ff == $past(wr_hold_ff))
		else $error("data register missed a write");
	AST_CMD_START: assert property (data_wr && unlocked_ff && !cmd_act_ff && legal && !rst_req_ff
		|=> flash_cmd_vld && flash_cmd == $past(wr_hold_ff) ##1 !flash_cmd_vld)
		else $error("legal command not issued as one pulse");
	AST_PIN_RESET: assert property (!pin_s [*8] |-> rst_cnt_ff != 12'h000)
		else $error("low clock pin not counted toward reset");
	AST_ADDR_STEER: assert property (wr_ev && wr_is_addr_ff && !rst_req_ff
		|=> addr_ff == $past(wr_hold_ff) && !flash_cmd_vld && !flash_byte_vld)
		else $error("address write not steered");
	AST_BAD_CMD: assert property (data_wr && !cmd_act_ff && !legal |=> !flash_cmd_vld && !flash_byte_vld)
		else $error("unknown command reached flash");
	AST_LOCKED: assert property (!unlocked_ff |=> !flash_cmd_vld)
		else $error("command issued while locked");

	COV_UNLOCK: cover property (!prog_unlocked ##1 prog_unlocked);
	COV_CMD: cover property (flash_cmd_vld ##[1:200] flash_byte_vld);
	COV_PIN_RST: cover property (sys_reset_req);

endmodule : dlfp_top

/* test/dlfp_prog_model.sv */
// programmer model: frames on the debug link, reset by holding the clock pin low
// assumes the device samples the data pin on link clock rise
`timescale 1ns/1ps

module dlfp_prog_model (
	output logic link_clk,
	output logic data_wire,
	input wire logic dev_out,
	input wire logic dev_oe_n
);
	logic pin_out;

	// ----------------------------------------
	// link wire and bit timing
	// ----------------------------------------
	assign data_wire = dev_oe_n ? pin_out : dev_out;

	initial
	begin
		link_clk = 1'b1;
		pin_out = 1'b0;
	end

	task automatic bit_out(input logic b);
		link_clk = 1'b0;
		pin_out = b;
		#80;
		link_clk = 1'b1;
		#80;
	endtask : bit_out

	task automatic period(output logic s);
		link_clk = 1'b0;
		#80;
		s = data_wire;
		link_clk = 1'b1;
		#80;
	endtask : period

	// ----------------------------------------
	// frames
	// ----------------------------------------
	// address steers data
	task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		logic s;
		rd = 8'h00;
		bit_out(1'b1);
		bit_out(ins[0]);
		bit_out(ins[1]);
		if (ins[0] ^ ins[1])
		begin
			for (n = 0; n < 8; n++)
				bit_out(wd[n]);
		end
		else
		begin
			pin_out = ~pin_out;
			s = 1'b0;
			for (n = 0; n < 64 && !s; n++)
				period(s);
			for (n = 0; n < 8; n++)
				period(rd[n]);
			if (!s)
				rd = 8'hXX;
		end
		#320;
	endtask : frame

	task automatic hold_low(input int ns);
		pin_out = 1'b0;
		link_clk = 1'b0;
		#(ns);
	endtask : hold_low

	task automatic release_pin();
		link_clk = 1'b1;
		#400;
	endtask : release_pin
endmodule : dlfp_prog_model

/* test/dlfp_top_bench.sv */
// bench of the debug-link flash programming registers
// assumes the programmer model drives the link and the bench the flash side
`timescale 1ns/1ps
`include "dlfp_defs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("mismatch %s exp %h got %h", nm, ex, got); end end

module dlfp_top_bench;
	logic ref_clk, sys_rst, link_clk, data_wire, dev_out, dev_oe_n;
	logic flash_done, flash_rd_vld, flash_cmd_vld, flash_byte_vld, prog_unlocked, sys_reset_req;
	logic [7:0] flash_rd_data, flash_cmd, flash_byte, rd, bv;
	logic [7:0] cmds [4] = '{`DLFP_CMD_BLK_READ, `DLFP_CMD_BLK_WRITE,
		`DLFP_CMD_PAGE_ERASE, `DLFP_CMD_DEV_ERASE};
	int mismatches = 0, n_checks = 0, n_cmd = 0, n_byte = 0, i;

	dlfp_top i_dlfp_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.debug_link_clock_pin(link_clk), .debug_link_data_pin_in(data_wire),
		.debug_link_data_pin_out(dev_out), .debug_link_data_pin_oe_n(dev_oe_n),
		.flash_done(flash_done), .flash_rd_vld(flash_rd_vld), .flash_rd_data(flash_rd_data),
		.flash_cmd_vld(flash_cmd_vld), .flash_cmd(flash_cmd), .flash_byte_vld(flash_byte_vld),
		.flash_byte(flash_byte), .prog_unlocked(prog_unlocked), .sys_reset_req(sys_reset_req));
	dlfp_prog_model i_dlfp_prog_model (.link_clk(link_clk), .data_wire(data_wire),
		.dev_out(dev_out), .dev_oe_n(dev_oe_n));

	// ----------------------------------------
	// clock, pulse counters, tasks
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		if (flash_cmd_vld === 1'b1)
			n_cmd <= n_cmd + 1;
		if (flash_byte_vld === 1'b1)
			n_byte <= n_byte + 1;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_dlfp_prog_model.frame(`DLFP_INS_ADDR_WR, a, rd);
		i_dlfp_prog_model.frame(`DLFP_INS_DATA_WR, d, rd);
	endtask : wr

	task automatic rdreg(input logic [7:0] a);
		i_dlfp_prog_model.frame(`DLFP_INS_ADDR_WR, a, rd);
		i_dlfp_prog_model.frame(`DLFP_INS_DATA_RD, 8'h00, rd);
	endtask : rdreg

	task automatic strobe(input logic sel_rd);
		@(negedge ref_clk);
		flash_done = !sel_rd;
		flash_rd_vld = sel_rd;
		@(negedge ref_clk);
		flash_done = 1'b0;
		flash_rd_vld = 1'b0;
	endtask : strobe

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		#300000;
		mismatches++;
		print_verdict();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		sys_rst = 1'b1;
		flash_done = 1'b0;
		flash_rd_vld = 1'b0;
		flash_rd_data = 8'h00;
		repeat (4) i_dlfp_prog_model.bit_out(1'b0);
		@(negedge ref_clk);
		sys_rst = 1'b0;
		// idle link edges while the synced reset lets go of the link side
		repeat (3) i_dlfp_prog_model.bit_out(1'b0);
		rdreg(`DLFP_ADDR_CTRL);
		`CHK("ctrl reset", 8'h00, rd)
		rdreg(`DLFP_ADDR_DATA);
		`CHK("data reset", 8'h00, rd)
		wr(8'h55, 8'hA5);
		rdreg(8'h55);
		`CHK("unmapped read", 8'h00, rd)
		i_dlfp_prog_model.frame(`DLFP_INS_ADDR_RD, 8'h00, rd);
		`CHK("address reg", 8'h55, rd)
		wr(`DLFP_ADDR_DATA, `DLFP_CMD_BLK_WRITE);
		`CHK("locked cmd", 0, n_cmd)
		rdreg(`DLFP_ADDR_DATA);
		`CHK("data stored", 8'h07, rd)
		wr(`DLFP_ADDR_CTRL, `DLFP_UNLOCK_2);
		wr(`DLFP_ADDR_CTRL, `DLFP_UNLOCK_1);
		`CHK("wrong order", 1'b0, prog_unlocked)
		rdreg(`DLFP_ADDR_CTRL);
		`CHK("ctrl readback", 8'h02, rd)
		wr(`DLFP_ADDR_CTRL, `DLFP_UNLOCK_2);
		`CHK("unlocked", 1'b1, prog_unlocked)
		for (i = 0; i < 4; i++)
		begin
			wr(`DLFP_ADDR_DATA, cmds[i]);
			`CHK("cmd count", i + 1, n_cmd)
			`CHK("cmd code", cmds[i], flash_cmd)
			bv = 8'hA0 | i[7:0];
			wr(`DLFP_ADDR_DATA, bv);
			`CHK("byte count", i + 1, n_byte)
			`CHK("byte value", bv, flash_byte)
			strobe(1'b0);
		end
		flash_rd_data = 8'h3C;
		strobe(1'b1);
		rdreg(`DLFP_ADDR_DATA);
		`CHK("flash read byte", 8'h3C, rd)
		wr(`DLFP_ADDR_DATA, 8'h09);
		`CHK("unknown cmd", 4, n_cmd)
		`CHK("still unlocked", 1'b1, prog_unlocked)
		i_dlfp_prog_model.hold_low(19000);
		`CHK("short low", 1'b0, sys_reset_req)
		i_dlfp_prog_model.hold_low(1100);
		`CHK("pin reset", 1'b1, sys_reset_req)
		`CHK("relocked", 1'b0, prog_unlocked)
		i_dlfp_prog_model.release_pin();
		`CHK("reset released", 1'b0, sys_reset_req)
		rdreg(`DLFP_ADDR_CTRL);
		`CHK("ctrl cleared", 8'h00, rd)
		print_verdict();
	end
endmodule : dlfp_top_bench
